// file: core/maf_memory_address_formation.v
// Address formation, indirect resolution and memory access front end
// Timing: a direct reference answers one cycle after startRef, and every
// indirect level adds two cycles, one to drive the word address and one
// to take the word. The core array answers combinationally while coreRd
// stands, so its word is taken at the edge that ends the strobe.
// A request other than byteReq that arrives while busy is high is not taken; the master
// waits for busy low. Holding the chain in one sequencer keeps a single
// core port, at the price of no overlap between references.
// Locations 2 to 077 octal stay ordinary memory; isReserved only marks
// an access that lands there.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "maf_defines.vh"

module maf_memory_address_formation #(
  parameter MEM_K = 32 // Installed size in K words: 4,8,12,16,24,32
) (
  input wire core_clk, // Clock, 100 MHz
  input wire reset, // Asynchronous reset, active high
  input wire loaderEnable, // Panel switch opening the loader area
  input wire startRef, // Pulse: resolve a memory reference
  input wire extRef, // 1: address word given (extended arithmetic)
  input wire [15:0] instrWord, // Instruction or address word
  input wire [14:0] progCounter, // Address of the instruction
  input wire memReq, // Pulse: plain access at accessAddr
  input wire memWrite, // Access direction, 1 writes
  input wire [14:0] accessAddr, // Address of the plain access
  input wire [15:0] writeData, // Data for a write
  input wire dblRead, // Pulse: read doubleword at accessAddr
  input wire byteReq, // Pulse: split writeData into bytes
  input wire [15:0] accLo, // First accumulator contents
  input wire [15:0] accHi, // Second accumulator contents
  input wire [15:0] coreRdata, // Core array read data
  input wire coreParityErr, // Core array parity fault
  output reg [14:0] coreAddr, // Core array address
  output reg coreRd, // Core array read strobe
  output reg coreWr, // Core array write strobe
  output reg [15:0] coreWdata, // Core array write data
  output reg accWrLo, // Write strobe, first accumulator
  output reg accWrHi, // Write strobe, second accumulator
  output reg [15:0] accWdata, // Accumulator write data
  output reg [14:0] effAddr, // Resolved effective address
  output reg refDone, // Pulse: effAddr valid
  output reg [15:0] readData, // Word read
  output reg readValid, // Pulse: readData valid
  output reg parityErr, // Pulse: parity fault on real memory
  output reg [31:0] dblData, // Doubleword, high word in 31:16
  output reg dblValid, // Pulse: dblData valid
  output reg [7:0] byteOut, // Byte for character transfer
  output reg byteValid, // Pulse: byteOut valid
  output reg isReserved, // Last address in locations 2..77 octal
  output reg busy // Sequencer busy
);

  ////////////////////////////////////////////////////////////////////////
  // States, one-hot
  // IDLE waits for a request; IND drives an indirect word address;
  // IWAIT takes the word and chains or finishes; RD and DHI drive a
  // data read (DHI the high half of a doubleword); RWAIT takes it.
  localparam S_IDLE = 6'h01;
  localparam S_IND = 6'h02;
  localparam S_IWAIT = 6'h04;
  localparam S_RD = 6'h08;
  localparam S_RWAIT = 6'h10;
  localparam S_DHI = 6'h20;

  // Size in words; loader base follows
  localparam integer MEM_SIZE = MEM_K * `MAF_PAGE_WORDS;
  localparam integer LOADER_SIZE = MEM_SIZE - `MAF_LOADER_WORDS;
  // 16 bits hold 32K exactly, which a 15-bit address could not
  localparam [15:0] MEM_WORDS = MEM_SIZE[15:0];
  localparam [15:0] LOADER_BASE = LOADER_SIZE[15:0];

  ////////////////////////////////////////////////////////////////////////
  // Nonexistent location test: beyond size or locked loader area
  // Limitation: a MEM_K outside the six legal sizes is not trapped
  function nonExist;
    input [14:0] a;
    input en;
    begin
      nonExist = ({1'b0, a} >= MEM_WORDS) ||
        (!en && {1'b0, a} >= LOADER_BASE);
    end
  endfunction

  // Accumulator window at the bottom of page zero
  function isAcc;
    input [14:0] a;
    begin
      isAcc = (a == `MAF_ADDR_ACC_LO) || (a == `MAF_ADDR_ACC_HI);
    end
  endfunction

  // Reserved area holding exit and interrupt locations
  // These stay ordinary memory; isReserved only marks an access
  function inReserved;
    input [14:0] a;
    begin
      inReserved = (a >= `MAF_ADDR_EXIT0) &&
        (a <= `MAF_ADDR_INT_LAST);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Panel switch comes from outside, two flops first
  // The lag delays a flip two cycles, so it can still act on a request already taken
  reg loadEnMeta;
  reg loadEn;
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      loadEnMeta <= 1'b0;
      loadEn <= 1'b0;
    end
    else
    begin
      loadEnMeta <= loaderEnable;
      loadEn <= loadEnMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Direct address: page zero forces bits 10..14 low
  // Extended references bring a full 15-bit address word instead
  wire [14:0] directAddr;
  assign directAddr = instrWord[`MAF_PAGE_BIT] ?
    {progCounter[14:10], instrWord[9:0]} :
    {5'h00, instrWord[9:0]};
  wire [14:0] startAddr;
  assign startAddr = extRef ? instrWord[14:0] : directAddr;

  reg [5:0] state;
  reg [5:0] next_state;
  reg [14:0] curAddr;
  reg dblPend;
  reg [15:0] lowWord;
  reg [7:0] lowByte;
  reg bytePend;
  reg lowWordSet; // Low word of a doubleword is held

  // Word read path: accumulator, nonexistent zero, or core data
  // Accumulators win, so addresses 0 and 1 never reach the core
  wire curNx;
  assign curNx = nonExist(curAddr, loadEn);
  wire [15:0] fetched;
  assign fetched = isAcc(curAddr) ?
    (curAddr[0] ? accHi : accLo) :
    (curNx ? `MAF_RESET_WORD : coreRdata);

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
        if (startRef)
          next_state = (instrWord[`MAF_DI_BIT]) ? S_IND : S_IDLE;
        else if (memReq && !memWrite)
          next_state = S_RD;
        else if (dblRead)
          next_state = S_RD;
      S_IND:
        next_state = S_IWAIT;
      S_IWAIT:
        // A set flag in the fetched word chains another level
        next_state = fetched[`MAF_DI_BIT] ? S_IND : S_IDLE;
      S_RD:
        next_state = S_RWAIT;
      S_RWAIT:
        next_state = dblPend ? S_DHI : S_IDLE;
      S_DHI:
        next_state = S_RWAIT;
      default:
        next_state = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and datapath
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= S_IDLE;
      curAddr <= 15'h0000;
      dblPend <= 1'b0;
      lowWord <= 16'h0000;
      coreAddr <= 15'h0000;
      coreRd <= 1'b0;
      coreWr <= 1'b0;
      coreWdata <= 16'h0000;
      accWrLo <= 1'b0;
      accWrHi <= 1'b0;
      accWdata <= 16'h0000;
      effAddr <= 15'h0000;
      refDone <= 1'b0;
      readData <= 16'h0000;
      readValid <= 1'b0;
      parityErr <= 1'b0;
      dblData <= 32'h00000000;
      dblValid <= 1'b0;
      isReserved <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      busy <= (next_state != S_IDLE);
      // Strobes fall by default, so each stands one cycle
      coreRd <= 1'b0;
      coreWr <= 1'b0;
      accWrLo <= 1'b0;
      accWrHi <= 1'b0;
      refDone <= 1'b0;
      readValid <= 1'b0;
      parityErr <= 1'b0;
      dblValid <= 1'b0;
      case (state)
        S_IDLE:
          if (startRef)
          begin
            curAddr <= startAddr;
            isReserved <= inReserved(startAddr);
            if (!instrWord[`MAF_DI_BIT])
            begin
              effAddr <= startAddr;
              refDone <= 1'b1;
            end
          end
          else if (memReq && memWrite)
          begin
            // Writes land in an accumulator, core, or nowhere
            isReserved <= inReserved(accessAddr);
            if (isAcc(accessAddr))
            begin
              accWrLo <= ~accessAddr[0];
              accWrHi <= accessAddr[0];
              accWdata <= writeData;
            end
            else if (!nonExist(accessAddr, loadEn))
            begin
              coreAddr <= accessAddr;
              coreWdata <= writeData;
              coreWr <= 1'b1;
            end
            // Otherwise dropped; only isReserved is updated
          end
          else if (memReq || dblRead)
          begin
            curAddr <= accessAddr;
            dblPend <= dblRead;
            isReserved <= inReserved(accessAddr);
          end
        S_IND, S_RD, S_DHI:
        begin
          // Core is only strobed for real locations
          coreAddr <= curAddr;
          coreRd <= !isAcc(curAddr) && !curNx;
        end
        S_IWAIT:
        begin
          if (!isAcc(curAddr) && !curNx && coreParityErr)
            parityErr <= 1'b1;
          // The fetched word's own flag decides if the chain goes on
          curAddr <= fetched[14:0];
          if (!fetched[`MAF_DI_BIT])
          begin
            effAddr <= fetched[14:0];
            refDone <= 1'b1;
          end
        end
        S_RWAIT:
        begin
          // Parity is flagged only for real core
          if (!isAcc(curAddr) && !curNx && coreParityErr)
            parityErr <= 1'b1;
          if (dblPend)
          begin
            // Low word held; the next address gives the high word
            lowWord <= fetched;
            curAddr <= curAddr + 15'h0001;
            dblPend <= 1'b0;
          end
          else
          begin
            readData <= fetched; // Word passed whole
            readValid <= 1'b1;
            if (lowWordSet)
            begin
              // Second word closes a doubleword, high in 31:16
              dblData <= {fetched, lowWord};
              dblValid <= 1'b1;
            end
          end
        end
        default:
        begin
          // An illegal code drops any doubleword in flight
          dblPend <= 1'b0;
        end
      endcase
    end
  end

  // Marks that the low word of a doubleword is held
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
      lowWordSet <= 1'b0;
    else if (state == S_RWAIT && dblPend)
      lowWordSet <= 1'b1;
    else if (state == S_RWAIT)
      lowWordSet <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte split: high byte one cycle, low byte the next
  // The low byte is kept, so writeData may move after byteReq
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      byteOut <= 8'h00;
      byteValid <= 1'b0;
      bytePend <= 1'b0;
      lowByte <= 8'h00;
    end
    else if (bytePend)
    begin
      byteOut <= lowByte;
      byteValid <= 1'b1;
      bytePend <= 1'b0;
    end
    else if (byteReq)
    begin
      byteOut <= writeData[15:8];
      lowByte <= writeData[7:0];
      byteValid <= 1'b1;
      bytePend <= 1'b1;
    end
    else
      byteValid <= 1'b0;
  end

endmodule

// file: core/maf_defines.vh
// Constants of the memory address formation block
`ifndef MAF_DEFINES_VH
`define MAF_DEFINES_VH
`define MAF_WORD_W 16
`define MAF_ADDR_W 15
`define MAF_SIGN_BIT 15
`define MAF_DI_BIT 15
`define MAF_PAGE_BIT 10
`define MAF_OFS_W 10
`define MAF_PAGE_WORDS 1024
`define MAF_LOADER_WORDS 64
`define MAF_ADDR_ACC_LO 15'h0000
`define MAF_ADDR_ACC_HI 15'h0001
`define MAF_ADDR_EXIT0 15'h0002
`define MAF_ADDR_EXIT1 15'h0003
`define MAF_ADDR_PWRFAIL 15'h0004
`define MAF_ADDR_PARITY 15'h0005
`define MAF_ADDR_DMA0 15'h0006
`define MAF_ADDR_DMA1 15'h0007
`define MAF_ADDR_INT_FIRST 15'h0008
`define MAF_ADDR_INT_LAST 15'h003F
`define MAF_FP_EXP_SIGN 0
`define MAF_FP_EXP_HI 7
`define MAF_RESET_WORD 16'h0000
`endif

// file: sim/maf_core_model.sv
// Behavioural core memory array beside the address block
`timescale 1ns/1ns
module maf_core_model (
  input wire core_clk, // Clock
  input wire [14:0] coreAddr, // Word address
  input wire coreRd, // Read strobe
  input wire coreWr, // Write strobe
  input wire [15:0] coreWdata, // Write data
  input wire faultOn, // Bench asks for parity faults
  output wire [15:0] coreRdata, // Read data while coreRd stands
  output wire coreParityErr // Fault flag, shown for every address
);
  reg [15:0] mem [0:32767]; // 16-bit words
  integer i;
  // Cleared array so reads of untouched words are known
  initial
  begin
    for (i = 0; i < 32768; i = i + 1)
      mem[i] = 16'h0000;
  end
  // Word read as the strobe stands; inverted outside it
  assign coreRdata = coreRd ? mem[coreAddr] : ~mem[coreAddr];
  // Fault shown regardless, so the block must mask it itself
  assign coreParityErr = faultOn;
  // Writes land at the edge that ends the strobe
  always @(posedge core_clk)
  begin
    if (coreWr)
      mem[coreAddr] <= coreWdata;
  end
endmodule

// file: sim/maf_memory_address_formation_checker.sv
// Port assertions for the address formation block
`timescale 1ns/1ns
module maf_checker #(
  parameter MEM_K = 32 // Installed size in K words
) (
  input wire core_clk, // Clock
  input wire reset, // Reset
  input wire loaderEnable, // Panel switch
  input wire startRef, // Reference request
  input wire extRef, // Address word mode
  input wire [15:0] instrWord, // Instruction
  input wire [14:0] progCounter, // Counter
  input wire memReq, // Access request
  input wire memWrite, // Direction
  input wire [14:0] accessAddr, // Access address
  input wire [15:0] writeData, // Write data
  input wire byteReq, // Byte split request
  input wire [14:0] coreAddr, // Core address
  input wire coreWr, // Core write
  input wire [15:0] coreWdata, // Core data
  input wire accWrLo, // First accumulator write
  input wire accWrHi, // Second accumulator write
  input wire [15:0] accWdata, // Accumulator data
  input wire [14:0] effAddr, // Effective address
  input wire refDone, // Reference done
  input wire [15:0] readData, // Read word
  input wire readValid, // Read done
  input wire parityErr, // Parity fault
  input wire [7:0] byteOut, // Byte
  input wire byteValid, // Byte valid
  input wire busy // Busy
);
  localparam LIM = MEM_K * 1024;
  reg [14:0] eaExp;
  reg [15:0] wd1, wd2;
  reg [14:0] ad1;
  reg [2:0] swHist;
  wire wrReq = memReq && memWrite && !busy;
  wire rdReq = memReq && !memWrite && !busy;
  wire beyond = accessAddr >= LIM;
  // Locked only once the switch has been low past its two-flop lag
  wire locked = accessAddr >= LIM - 64 && !beyond && swHist == 3'h0
    && !loaderEnable;
  ////////////////////////////////////////////////////////////////////////////
  // Request fields delayed so late results can be matched
  always @(posedge core_clk)
  begin
    eaExp <= {instrWord[10] ? progCounter[14:10] : 5'h00, instrWord[9:0]};
    wd1 <= writeData;
    wd2 <= wd1;
    ad1 <= accessAddr;
    swHist <= {swHist[1:0], loaderEnable};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_direct_page: assert property (
    startRef && !busy && !extRef && !instrWord[15] |=> refDone
    && effAddr == eaExp) else $error("direct address wrong");
  a_acc_lo_write: assert property (
    wrReq && accessAddr == 15'h0000 |=> accWrLo && !accWrHi && !coreWr
    && accWdata == wd1) else $error("first accumulator write wrong");
  a_acc_hi_write: assert property (
    wrReq && accessAddr == 15'h0001 |=> accWrHi && !accWrLo && !coreWr
    && accWdata == wd1) else $error("second accumulator write wrong");
  a_core_write: assert property (
    wrReq && accessAddr > 1 && accessAddr < LIM - 64 |=> coreWr
    && coreAddr == ad1 && coreWdata == wd1) else $error("core write wrong");
  a_beyond_drop: assert property (
    wrReq && beyond |=> (!coreWr && !accWrLo && !accWrHi) [*3])
    else $error("write beyond size not dropped");
  a_loader_lock: assert property (
    wrReq && locked |=> !coreWr [*3]) else $error("loader write leaked");
  a_nonexist_read: assert property (
    rdReq && (beyond || locked) |-> ##3 readValid && readData == 16'h0000
    && !parityErr) else $error("nonexistent read wrong");
  a_byte_order: assert property (
    byteReq && !busy |=> byteValid && byteOut == wd1[15:8] ##1 byteValid
    && byteOut == wd2[7:0]) else $error("byte order wrong");
endmodule
bind maf_memory_address_formation maf_checker #(.MEM_K(MEM_K)) chk (
  .core_clk, .reset, .loaderEnable, .startRef, .extRef, .instrWord,
  .progCounter, .memReq, .memWrite, .accessAddr, .writeData, .byteReq,
  .coreAddr, .coreWr, .coreWdata, .accWrLo, .accWrHi, .accWdata, .effAddr,
  .refDone, .readData, .readValid, .parityErr, .byteOut, .byteValid, .busy);

// file: sim/test_memory_address_formation.sv
// Self-checking bench for the address formation block
`timescale 1ns/1ns
module test_memory_address_formation;
  localparam LIM = 4096;
  reg core_clk = 1'h0, reset = 1'h1, loaderEnable = 1'h0, startRef = 1'h0;
  reg extRef = 1'h0, memReq = 1'h0, memWrite = 1'h0, dblRead = 1'h0;
  reg byteReq = 1'h0, faultOn = 1'h0, gotPar = 1'h0;
  reg [15:0] instrWord = 16'h0000, writeData = 16'h0000, accLo = 16'h0000;
  reg [15:0] accHi = 16'h0000, gotRd, gotEa, gotBytes, w;
  reg [14:0] progCounter = 15'h0000, accessAddr = 15'h0000, a;
  reg [31:0] gotDbl;
  reg [15:0] shadow [0:32767];
  integer seed = 32'hDC54, err_count = 0, n_tests = 0, i, k;
  wire [14:0] coreAddr, effAddr;
  wire [15:0] coreWdata, coreRdata, accWdata, readData;
  wire [31:0] dblData;
  wire [7:0] byteOut;
  wire coreRd, coreWr, accWrLo, accWrHi, refDone, readValid, parityErr;
  wire dblValid, byteValid, isReserved, busy, coreParityErr;
  // 4K installed so the beyond-size range can be reached
  maf_memory_address_formation #(.MEM_K(4)) DUT (.core_clk, .reset,
    .loaderEnable, .startRef, .extRef, .instrWord, .progCounter, .memReq,
    .memWrite, .accessAddr, .writeData, .dblRead, .byteReq, .accLo, .accHi,
    .coreRdata, .coreParityErr, .coreAddr, .coreRd, .coreWr, .coreWdata,
    .accWrLo, .accWrHi, .accWdata, .effAddr, .refDone, .readData,
    .readValid, .parityErr, .dblData, .dblValid, .byteOut, .byteValid,
    .isReserved, .busy);
  maf_core_model MEM (.core_clk, .coreAddr, .coreRd, .coreWr, .coreWdata,
    .faultOn, .coreRdata, .coreParityErr);
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 100 MHz
  always #5 core_clk = ~core_clk;
  // Result pulses stand one cycle, so they are latched here
  always @(posedge core_clk)
  begin
    if (refDone)
      gotEa <= {1'h0, effAddr};
    if (readValid)
      gotRd <= readData;
    if (dblValid)
      gotDbl <= dblData;
    if (byteValid)
      gotBytes <= {gotBytes[7:0], byteOut};
    if (parityErr)
      gotPar <= 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  function exists(input [14:0] ad);
    exists = ad < LIM - 64 || (ad < LIM && loaderEnable);
  endfunction
  function [15:0] expRead(input [14:0] ad);
    expRead = !exists(ad) ? 16'h0000 : ad == 0 ? accLo : ad == 1 ? accHi
      : shadow[ad];
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Kinds: 0 read, 1 write, 2 reference, 3 doubleword, 4 bytes
  task op(input [2:0] kind, input [14:0] ad, input [15:0] d);
    begin
      gotRd <= 16'hXXXX;
      gotEa <= 16'hXXXX;
      gotDbl <= 32'hXXXXXXXX;
      gotBytes <= 16'hXXXX;
      gotPar <= 1'h0;
      memReq <= kind < 2;
      memWrite <= kind == 1;
      startRef <= kind == 2;
      dblRead <= kind == 3;
      byteReq <= kind == 4;
      accessAddr <= ad;
      progCounter <= ad;
      writeData <= d;
      instrWord <= d;
      if (kind == 1 && ad > 1 && exists(ad))
        shadow[ad] = d;
      @(posedge core_clk);
      memReq <= 1'h0;
      startRef <= 1'h0;
      dblRead <= 1'h0;
      byteReq <= 1'h0;
      for (k = 0; k < 16 && (k < 4 || busy !== 1'h0); k = k + 1)
        @(posedge core_clk);
      @(posedge core_clk);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    for (i = 0; i < 32768; i = i + 1)
      shadow[i] = 16'h0000;
    repeat (10) @(posedge core_clk);
    reset <= 1'h0;
    accLo <= $random(seed);
    accHi <= $random(seed);
    @(posedge core_clk);
    for (i = 0; i < 20; i = i + 1)
    begin
      w = $random(seed) & 16'h7FFF;
      a = $random(seed);
      op(2, a, w);
      check(gotEa, {1'h0, w[10] ? a[14:10] : 5'h00, w[9:0]});
    end
    $display("direct reference test done");
    op(1, 15'h0100, 16'h8200);
    op(1, 15'h0200, 16'h7ABC);
    op(1, 15'h0101, 16'hC3A5);
    for (i = 0; i < 2; i = i + 1)
    begin
      extRef <= i[0];
      op(2, 15'h0400, 16'h8100);
      check(gotEa, 16'h7ABC);
    end
    op(2, 15'h0400, 16'h2345);
    check(gotEa, 16'h2345);
    extRef <= 1'h0;
    op(3, 15'h0100, 16'h0000);
    check(gotDbl, {shadow[257], shadow[256]});
    op(3, 15'h0000, 16'h0000);
    check(gotDbl, {accHi, accLo});
    for (i = 0; i < 4; i = i + 1)
    begin
      w = $random(seed);
      op(4, 15'h0000, w);
      check(gotBytes, w);
    end
    $display("indirect, doubleword and byte tests done");
    op(1, LIM - 1, 16'hBEEF);
    for (i = 0; i < 40; i = i + 1)
    begin
      if (i == 20)
      begin
        loaderEnable <= 1'h1;
        repeat (3) @(posedge core_clk);
        op(0, LIM - 1, 16'h0000);
        check(gotRd, 16'h0000);
      end
      a = i[0] ? LIM - 68 + ($random(seed) & 16'h007F) : $random(seed);
      if (i < 4)
        a = i[14:0];
      w = $random(seed);
      op(1, a, w);
      // Fault raised at random; only real core may report it
      faultOn <= w[3];
      op(0, a, 16'h0000);
      check(gotRd, expRead(a));
      check(gotPar, faultOn && exists(a) && a > 1);
      check(isReserved, a >= 2 && a <= 15'h003F);
    end
    $display("memory access test done");
    give_verdict;
  end
  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    err_count = err_count + 1;
    give_verdict;
  end
endmodule
